// file: dcc_consts.vh
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH
// Register byte offsets on the Wishbone bus.
`define DCC_ADR_CRC_CTRL 8'h00
`define DCC_ADR_TAP_MASK 8'h04
`define DCC_ADR_IRQ_STAT 8'h08
`define DCC_ADR_IRQ_MASK 8'h0C
`define DCC_ADR_CH_BASE 8'h10
`define DCC_ADR_CH_STEP 8'h04
`define DCC_ADR_GRANT 8'h30
// Channel control field positions.
`define DCC_CH_PRI_LO 0
`define DCC_CH_EVDET 2
`define DCC_CH_AUTO 4
`define DCC_CH_CHAIN 5
`define DCC_CH_EVDIS 6
`define DCC_CH_RUN 7
`define DCC_CH_CHDIR 8
`define DCC_CH_BUSY 15
// CRC control field positions.
`define DCC_CRC_ROUTE 7
`define DCC_CRC_TYPE 5
`define DCC_CRC_POLYNOMIAL_LENGTH_FIELD_LO 8
// Reset values.
`define DCC_RST_TAP 32'h00000000
`define DCC_RST_CTRL 32'h00000000
// Drain count loaded on suspend; busy clears on transaction done or at most 4 cycles after run clears.
`define DCC_DRAIN_CYCLES 4'h3
`endif

// file: dcc_lfsr.v
`timescale 1ns/1ps
`include "dcc_consts.vh"
// CRC shift register: LFSR with per-stage feedback, or a 16-bit ones-complement sum.
module dcc_lfsr #(
	parameter W = 32
) (
	input wire clk_i,
	input wire rst_i,
	input wire seed_i,
	input wire [W-1:0] seed_val_i,
	input wire shift_i,
	input wire data_bit_i,
	input wire [15:0] word_i,
	input wire sum_i,
	input wire type_sel_i,
	input wire [4:0] polynomial_length_field_i,
	input wire [W-1:0] tap_mask_i,
	output reg [W-1:0] crc_o
);
	wire fb;
	wire [W-1:0] next_lfsr;
	wire [16:0] add;
	// Feedback is the top active stage mixed with the incoming bit.
	assign fb = crc_o[polynomial_length_field_i] ^ data_bit_i;
	assign add = {1'b0, crc_o[15:0]} + {1'b0, word_i};
	// Each active stage either takes the XOR feedback or the previous stage as is; stages above the length clear to zero.
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_stage
			if (i == 0) begin : g0
				assign next_lfsr[i] = (i <= polynomial_length_field_i) ? fb : 1'b0;
			end else begin : gn
				assign next_lfsr[i] = (i > polynomial_length_field_i) ? 1'b0 :
					(tap_mask_i[i] ? (crc_o[i-1] ^ fb) : crc_o[i-1]);
			end
		end
	endgenerate
	// Checksum mode ignores the tap mask entirely.
	always @(posedge clk_i) begin
		if (rst_i) begin
			crc_o <= {W{1'b0}};
		end else if (seed_i) begin
			crc_o <= seed_val_i;
		end else if (type_sel_i) begin
			if (sum_i) begin
				crc_o <= {{(W-16){1'b0}}, add[15:0] + {15'h0000, add[16]}};
			end
		end else if (shift_i) begin
			crc_o <= next_lfsr;
		end
	end
endmodule

// file: dcc_top.v
// Notes on behaviour
// - In LFSR mode set tap bits add XOR feedback; clear bits pass stage through.
// - In checksum mode the tap mask is ignored.
// - Busy reads 1 while channel active or enabled, 0 once idle and disabled.
// - Chain direction set: higher channel completion enables; clear: lower channel.
// - Chain direction matters only while chain-allow is set.
// - Chain-allow permits chained enabling; clear prevents it.
// - Run bit starts channel; clearing suspends after in-flight transaction completes.
// - Events-while-disabled set latches start/abort events; clear discards them.
// - Auto re-enable keeps channel running after block; else run bit clears.
// - Event-detected flag is read only, set on channel event.
// - Two-bit priority 0..3, level 3 highest in arbitration.
// - Unimplemented channel control bits read as zero.
// - CRC type select: set is checksum, clear is LFSR.
// - Polynomial length field holds length minus one, sets active stages.
// - CRC route enable passes assigned channel data through CRC, else unaltered.
`timescale 1ns/1ps
`include "dcc_consts.vh"
module dcc_top #(
	parameter NCH = 8,
	parameter W = 32
) (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	output reg err_o,
	output reg irq_o,
	input wire [NCH-1:0] start_ev_i,
	input wire [NCH-1:0] abort_ev_i,
	input wire [NCH-1:0] block_done_i,
	input wire [NCH-1:0] txn_done_i,
	input wire [15:0] xfer_data_i,
	input wire xfer_valid_i,
	input wire [2:0] xfer_ch_i,
	output reg [15:0] xfer_data_o,
	output reg [NCH-1:0] grant_o,
	output reg [NCH-1:0] run_o,
	output reg [W-1:0] crc_value_o
);
	reg [NCH-1:0] run, chdir, chain, evdis, auto, evdet, busy;
	reg [1:0] pri [0:NCH-1];
	reg [3:0] drain [0:NCH-1];
	reg [W-1:0] tap_mask;
	reg crc_route, crc_type;
	reg [4:0] polynomial_length_field;
	reg [2:0] crc_ch;
	reg [2:0] irq_stat, irq_mask;
	reg [3:0] bitcnt;
	reg [15:0] shreg;
	reg shifting;
	wire req = cyc_i & stb_i & ~ack_o & ~err_o;
	wire wr = req & we_i;
	wire rd = req & ~we_i;
	wire [7:0] ch_off = adr_i - `DCC_ADR_CH_BASE;
	wire [7:0] ch_idx = {2'b00, ch_off[7:2]};
	wire ch_hit = (adr_i >= `DCC_ADR_CH_BASE) && (ch_idx < NCH) && (adr_i[1:0] == 2'b00);
	wire [W-1:0] crc_now;
	wire route_hit = crc_route & xfer_valid_i & (xfer_ch_i == crc_ch);
	integer k;
	reg [31:0] next_dat;
	reg hit;
	reg [NCH-1:0] next_grant;
	reg [1:0] best;
	reg found;

	// Channel control word assembled for reads; unimplemented bits stay zero.
	function [31:0] ctrl_word;
		input integer c;
		begin
			ctrl_word = 32'h00000000;
			ctrl_word[`DCC_CH_BUSY] = busy[c];
			ctrl_word[`DCC_CH_CHDIR] = chdir[c];
			ctrl_word[`DCC_CH_RUN] = run[c];
			ctrl_word[`DCC_CH_EVDIS] = evdis[c];
			ctrl_word[`DCC_CH_CHAIN] = chain[c];
			ctrl_word[`DCC_CH_AUTO] = auto[c];
			ctrl_word[`DCC_CH_EVDET] = evdet[c];
			ctrl_word[`DCC_CH_PRI_LO+1:`DCC_CH_PRI_LO] = pri[c];
		end
	endfunction

	// Read mux and address decode.
	always @* begin
		next_dat = 32'h00000000;
		hit = 1'b1;
		if (ch_hit) begin
			next_dat = ctrl_word(ch_idx);
		end else begin
			case (adr_i)
				`DCC_ADR_CRC_CTRL: begin
					next_dat[`DCC_CRC_ROUTE] = crc_route;
					next_dat[`DCC_CRC_TYPE] = crc_type;
					next_dat[`DCC_CRC_POLYNOMIAL_LENGTH_FIELD_LO+4:`DCC_CRC_POLYNOMIAL_LENGTH_FIELD_LO] = polynomial_length_field;
					next_dat[2:0] = crc_ch;
				end
				`DCC_ADR_TAP_MASK: next_dat = tap_mask;
				`DCC_ADR_IRQ_STAT: next_dat = {29'h00000000, irq_stat};
				`DCC_ADR_IRQ_MASK: next_dat = {29'h00000000, irq_mask};
				`DCC_ADR_GRANT: next_dat = {{(32-NCH){1'b0}}, grant_o};
				default: hit = 1'b0;
			endcase
		end
	end

	// Arbiter: highest level wins, lowest channel number breaks ties.
	always @* begin
		next_grant = {NCH{1'b0}};
		best = 2'b00;
		found = 1'b0;
		for (k = 0; k < NCH; k = k + 1) begin
			if (run[k] && (!found || pri[k] > best)) begin
				best = pri[k];
				found = 1'b1;
				next_grant = {NCH{1'b0}};
				next_grant[k] = 1'b1;
			end
		end
	end

	// Bus handshake: one wait state, error on an unmapped address.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req & hit;
			err_o <= req & ~hit;
			dat_o <= rd ? next_dat : 32'h00000000;
		end
	end

	// Per-channel control state.
	genvar c;
	generate
		for (c = 0; c < NCH; c = c + 1) begin : g_ch
			wire wsel = wr & ch_hit & (ch_idx == c);
			wire hi_done = (c < NCH - 1) ? block_done_i[(c + 1) % NCH] : 1'b0;
			wire lo_done = (c > 0) ? block_done_i[(c + NCH - 1) % NCH] : 1'b0;
			wire chained = chain[c] & (chdir[c] ? hi_done : lo_done);
			wire ev = (start_ev_i[c] | abort_ev_i[c]) & (run[c] | evdis[c]);
			always @(posedge clk_i) begin
				if (rst_i) begin
					run[c] <= 1'b0;
					chdir[c] <= 1'b0;
					chain[c] <= 1'b0;
					evdis[c] <= 1'b0;
					auto[c] <= 1'b0;
					evdet[c] <= 1'b0;
					busy[c] <= 1'b0;
					pri[c] <= 2'b00;
					drain[c] <= 4'h0;
				end else begin
					if (wsel && sel_i[0]) begin
						run[c] <= dat_i[`DCC_CH_RUN];
						evdis[c] <= dat_i[`DCC_CH_EVDIS];
						chain[c] <= dat_i[`DCC_CH_CHAIN];
						auto[c] <= dat_i[`DCC_CH_AUTO];
						pri[c] <= dat_i[`DCC_CH_PRI_LO+1:`DCC_CH_PRI_LO];
					end else if (chained) begin
						run[c] <= 1'b1;
					end else if (block_done_i[c] && !auto[c]) begin
						run[c] <= 1'b0;
					end
					if (wsel && sel_i[1]) begin
						chdir[c] <= dat_i[`DCC_CH_CHDIR];
					end
					// Event flag is set by hardware only; a write never touches it.
					if (ev) begin
						evdet[c] <= 1'b1;
					end else if (run[c] && (block_done_i[c] || abort_ev_i[c])) begin
						evdet[c] <= 1'b0;
					end
					// Busy follows run, but lingers while an in-flight transaction drains.
					if (wsel && sel_i[0] && dat_i[`DCC_CH_RUN]) begin
						busy[c] <= 1'b1;
						drain[c] <= `DCC_DRAIN_CYCLES;
					end else if (run[c] || chained) begin
						busy[c] <= 1'b1;
						drain[c] <= `DCC_DRAIN_CYCLES;
					end else if (busy[c]) begin
						if (txn_done_i[c] || drain[c] == 4'h0) begin
							busy[c] <= 1'b0;
						end else begin
							drain[c] <= drain[c] - 4'h1;
						end
					end
				end
			end
		end
	endgenerate

	// CRC control, tap mask and interrupt registers.
	always @(posedge clk_i) begin
		if (rst_i) begin
			tap_mask <= `DCC_RST_TAP;
			crc_route <= 1'b0;
			crc_type <= 1'b0;
			polynomial_length_field <= 5'h00;
			crc_ch <= 3'h0;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
		end else begin
			if (wr && adr_i == `DCC_ADR_TAP_MASK) begin
				if (sel_i[0]) tap_mask[7:0] <= dat_i[7:0];
				if (sel_i[1]) tap_mask[15:8] <= dat_i[15:8];
				if (sel_i[2]) tap_mask[23:16] <= dat_i[23:16];
				if (sel_i[3]) tap_mask[31:24] <= dat_i[31:24];
			end
			if (wr && adr_i == `DCC_ADR_CRC_CTRL) begin
				if (sel_i[0]) begin
					crc_route <= dat_i[`DCC_CRC_ROUTE];
					crc_type <= dat_i[`DCC_CRC_TYPE];
					crc_ch <= dat_i[2:0];
				end
				if (sel_i[1]) polynomial_length_field <= dat_i[`DCC_CRC_POLYNOMIAL_LENGTH_FIELD_LO+4:`DCC_CRC_POLYNOMIAL_LENGTH_FIELD_LO];
			end
			if (wr && adr_i == `DCC_ADR_IRQ_MASK && sel_i[0]) begin
				irq_mask <= dat_i[2:0];
			end
			// Sticky events: block end stopping a channel, start event seen, any block done; a read clears, a new event wins.
			irq_stat <= ((rd && adr_i == `DCC_ADR_IRQ_STAT) ? 3'h0 : irq_stat)
				| {|(run & ~auto & block_done_i), |(start_ev_i & (run | evdis)),
				|block_done_i};
		end
	end

	// Word stream serialiser feeding the LFSR one bit per cycle, MSB first.
	always @(posedge clk_i) begin
		if (rst_i) begin
			shreg <= 16'h0000;
			bitcnt <= 4'h0;
			shifting <= 1'b0;
		end else if (route_hit && !crc_type && !shifting) begin
			shreg <= xfer_data_i;
			bitcnt <= 4'hF;
			shifting <= 1'b1;
		end else if (shifting) begin
			shreg <= {shreg[14:0], 1'b0};
			bitcnt <= bitcnt - 4'h1;
			shifting <= (bitcnt != 4'h0);
		end
	end

	dcc_lfsr #(.W(W)) u_lfsr (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.seed_i(1'b0),
		.seed_val_i({W{1'b0}}),
		.shift_i(shifting),
		.data_bit_i(shreg[15]),
		.word_i(xfer_data_i),
		.sum_i(route_hit),
		.type_sel_i(crc_type),
		.polynomial_length_field_i(polynomial_length_field),
		.tap_mask_i(tap_mask),
		.crc_o(crc_now)
	);

	// Registered outputs.
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			grant_o <= {NCH{1'b0}};
			run_o <= {NCH{1'b0}};
			crc_value_o <= {W{1'b0}};
			xfer_data_o <= 16'h0000;
		end else begin
			irq_o <= |(irq_stat & irq_mask);
			grant_o <= next_grant;
			run_o <= run;
			crc_value_o <= crc_now;
			xfer_data_o <= xfer_data_i;
		end
	end
endmodule

// file: dcc_sva.sv
`timescale 1ns/1ps
// Watches bus answers, run-bit causes and the data path at the top ports.
module dcc_sva #(
	parameter NCH = 8
) (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	input wire ack_o,
	input wire err_o,
	input wire [NCH-1:0] run_o,
	input wire [NCH-1:0] grant_o,
	input wire [NCH-1:0] block_done_i,
	input wire [NCH-1:0] abort_ev_i,
	input wire xfer_valid_i,
	input wire [15:0] xfer_data_i,
	input wire [15:0] xfer_data_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A new request is taken, and a channel 0 control write lands.
	sequence s_take;
		cyc_i && stb_i && !ack_o && !err_o;
	endsequence
	sequence s_wr0;
		ack_o && we_i && sel_i[0] && adr_i == 8'h10;
	endsequence
	property p_map_ack;
		s_take ##0 adr_i == 8'h10 |=> ack_o && !err_o;
	endproperty
	a_map_ack: assert property (p_map_ack)
		else $error("mapped access got no ack");
	property p_unmap_err;
		s_take ##0 adr_i == 8'h40 |=> err_o && !ack_o;
	endproperty
	a_unmap_err: assert property (p_unmap_err)
		else $error("unmapped access got no error");
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	property p_run_set;
		s_wr0 ##0 dat_i[7] |=> run_o[0];
	endproperty
	a_run_set: assert property (p_run_set)
		else $error("run bit did not start");
	property p_run_clr;
		s_wr0 ##0 !dat_i[7] |=> !run_o[0];
	endproperty
	a_run_clr: assert property (p_run_clr)
		else $error("run bit did not clear");
	property p_run_fall;
		(~run_o & $past(run_o)) != 0 |-> $past(ack_o && we_i)
			|| $past(|(block_done_i | abort_ev_i), 2);
	endproperty
	a_run_fall: assert property (p_run_fall)
		else $error("run bit fell without cause");
	property p_run_rise;
		(run_o & ~$past(run_o)) != 0 |-> $past(ack_o && we_i) || $past(|block_done_i, 2);
	endproperty
	a_run_rise: assert property (p_run_rise)
		else $error("run bit rose without cause");
	property p_grant;
		$onehot0(grant_o);
	endproperty
	a_grant: assert property (p_grant)
		else $error("more than one grant");
	property p_pass;
		xfer_valid_i |=> xfer_data_o == $past(xfer_data_i);
	endproperty
	a_pass: assert property (p_pass)
		else $error("transfer data altered");
endmodule
bind dcc_top dcc_sva #(.NCH(NCH)) u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
	.sel_i, .dat_i, .ack_o, .err_o, .run_o, .grant_o, .block_done_i, .abort_ev_i,
	.xfer_valid_i, .xfer_data_i, .xfer_data_o);

// file: dcc_peer.sv
`timescale 1ns/1ps
// Stands in for memories and peripherals: ends transactions and blocks.
module dcc_peer #(
	parameter NCH = 8,
	parameter LAT = 2
) (
	input wire clk_i,
	input wire rst_i,
	input wire [NCH-1:0] run_i,
	input wire [NCH-1:0] blk_req_i,
	output reg [NCH-1:0] txn_done_o,
	output reg [NCH-1:0] block_done_o
);
	reg [3:0] cnt;
	// Running channels finish a transaction every LAT+1 cycles; blocks end on request.
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 4'h0;
			txn_done_o <= {NCH{1'b0}};
			block_done_o <= {NCH{1'b0}};
		end else begin
			cnt <= (cnt == LAT) ? 4'h0 : cnt + 4'h1;
			txn_done_o <= (cnt == LAT) ? run_i : {NCH{1'b0}};
			block_done_o <= blk_req_i & run_i;
		end
	end
endmodule

// file: tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, xv = 1'b0, e;
	logic [7:0] adr = 8'h00, blk = 8'h00, sev = 8'h00;
	logic [31:0] dat = 32'h0, q;
	logic [15:0] xd = 16'h0, xo;
	logic [31:0] dat_o, crc;
	logic ack_o, err_o, irq_o;
	logic [7:0] txn, bdone, grant, run;
	int fail_count = 0, samples_checked = 0, i;
	dcc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.irq_o(irq_o), .start_ev_i(sev), .abort_ev_i(8'h00), .block_done_i(bdone),
		.txn_done_i(txn), .xfer_data_i(xd), .xfer_valid_i(xv), .xfer_ch_i(3'h0),
		.xfer_data_o(xo), .grant_o(grant), .run_o(run), .crc_value_o(crc));
	dcc_peer #(.LAT(5)) u_peer (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .blk_req_i(blk),
		.txn_done_o(txn), .block_done_o(bdone));
	// Free-running 100 MHz clock.
	initial forever #5 clk_i = ~clk_i;
	// One classic Wishbone cycle; waits for ack or err, then one idle cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		q = dat_o;
		e = err_o;
		if (n == 20) fail_count++;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
		wb(1'b0, a, 32'h0);
		`CHK(n, x, q)
	endtask
	task automatic pulse_blk(input logic [7:0] m);
		blk <= m;
		@(posedge clk_i);
		blk <= 8'h00;
		repeat (3) @(posedge clk_i);
	endtask
	// Arms target t with control c, runs source s once to block end.
	task automatic chain(input int t, input logic [31:0] c, input int s, input logic x);
		wb(1'b1, 8'h10 + 8'(4 * t), c);
		wb(1'b1, 8'h10 + 8'(4 * s), 32'h80);
		pulse_blk(8'h01 << s);
		`CHK("chain run", x, run[t])
		`CHK("source run", 1'b0, run[s])
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		repeat (3000) @(posedge clk_i);
		fail_count++;
		summarize();
	end
	// Main sequence of register calls and checks.
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h04, 32'h0, "tap reset");
		rd(8'h10, 32'h0, "ctrl reset");
		wb(1'b1, 8'h04, 32'hA5A55A5A);
		rd(8'h04, 32'hA5A55A5A, "tap mask");
		wb(1'b1, 8'h10, 32'hFFFFFFFF);
		rd(8'h10, 32'h000081F3, "ctrl fields");
		wb(1'b1, 8'h10, 32'h0);
		i = 0;
		q = 32'h8000;
		while (q[15] !== 1'b0 && i < 10) begin
			wb(1'b0, 8'h10, 32'h0);
			i++;
		end
		`CHK("busy", 1'b0, q[15])
		chain(1, 32'h120, 2, 1'b1);
		`CHK("irq masked", 1'b0, irq_o)
		wb(1'b1, 8'h0C, 32'h1);
		@(posedge clk_i);
		`CHK("irq", 1'b1, irq_o)
		wb(1'b0, 8'h08, 32'h0);
		`CHK("status", 1'b1, q[0])
		@(posedge clk_i);
		`CHK("irq clear", 1'b0, irq_o)
		chain(1, 32'h020, 2, 1'b0);
		chain(3, 32'h020, 2, 1'b1);
		chain(5, 32'h100, 6, 1'b0);
		wb(1'b1, 8'h24, 32'h90);
		pulse_blk(8'h20);
		`CHK("auto run", 1'b1, run[5])
		wb(1'b1, 8'h28, 32'h40);
		sev <= 8'hC0;
		@(posedge clk_i);
		sev <= 8'h00;
		wb(1'b0, 8'h28, 32'h0);
		`CHK("event kept", 1'b1, q[2])
		wb(1'b0, 8'h2C, 32'h0);
		`CHK("event dropped", 1'b0, q[2])
		wb(1'b1, 8'h40, 32'h0);
		`CHK("unmapped", 1'b1, e)
		xd <= 16'hBEEF;
		xv <= 1'b1;
		@(posedge clk_i);
		xv <= 1'b0;
		@(posedge clk_i);
		`CHK("xfer data", 16'hBEEF, xo)
		// Channels 3 and 5 run at level 0, so the lower number wins; then 5 goes to level 3.
		rd(8'h30, 32'h08, "grant tie");
		wb(1'b1, 8'h24, 32'h93);
		rd(8'h30, 32'h20, "grant level");
		`CHK("grant port", 8'h20, grant)
		// Four-stage LFSR with taps on stages 1 and 3 takes one set bit then fifteen zeros.
		wb(1'b1, 8'h00, 32'h00000380);
		xd <= 16'h8000;
		xv <= 1'b1;
		@(posedge clk_i);
		xv <= 1'b0;
		repeat (20) @(posedge clk_i);
		`CHK("lfsr crc", 32'h00000002, crc)
		// Checksum mode adds two words with end-around carry, tap mask unused.
		wb(1'b1, 8'h00, 32'h000000A0);
		xd <= 16'h1234;
		xv <= 1'b1;
		@(posedge clk_i);
		xd <= 16'hF000;
		@(posedge clk_i);
		xv <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK("checksum", 32'h00000237, crc)
		summarize();
	end
endmodule
